// [hseq_sync.sv]
// Homing sequencer package and the pin input filter
`timescale 1ns/1ns
`default_nettype none

package hseq_pkg;
    // ****************************************************
    // Method codes handled by this sequencer
    // ****************************************************
    localparam logic [7:0] METHOD_POT_INDEX = 8'h02;
    localparam logic [7:0] METHOD_FIRST = 8'h02;
    localparam logic [7:0] METHOD_LAST = 8'h09;
    localparam logic [7:0] METHOD_3 = 8'h03;
    localparam logic [7:0] METHOD_4 = 8'h04;
    localparam logic [7:0] METHOD_5 = 8'h05;
    localparam logic [7:0] METHOD_6 = 8'h06;
    localparam logic [7:0] METHOD_7 = 8'h07;
    localparam logic [7:0] METHOD_8 = 8'h08;
    localparam logic [7:0] METHOD_9 = 8'h09;

    // ****************************************************
    // Segment row: {forward, high speed, leave event[1:0]}
    // ****************************************************
    localparam int ROW_W = 4;
    localparam int ROWS = 5;
    localparam int ROW_DIR_BIT = 3;
    localparam int ROW_HIGH_BIT = 2;
    localparam logic [1:0] EVT_RISE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h1;
    localparam logic [1:0] EVT_INDEX = 2'h2;
    localparam logic [3:0] SEG_FH_RISE = 4'hC;
    localparam logic [3:0] SEG_FL_RISE = 4'h8;
    localparam logic [3:0] SEG_FL_FALL = 4'h9;
    localparam logic [3:0] SEG_FL_INDEX = 4'hA;
    localparam logic [3:0] SEG_RH_RISE = 4'h4;
    localparam logic [3:0] SEG_RL_RISE = 4'h0;
    localparam logic [3:0] SEG_RL_FALL = 4'h1;
    localparam logic [3:0] SEG_RL_INDEX = 4'h2;
    localparam logic [3:0] SEG_NONE = 4'h0;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic [31:0] SPEED_RST = 32'h0000_0000;
    localparam logic [31:0] ACCEL_RST = 32'h0000_0001;
    localparam logic [2:0] SYNC_RST = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEEK,
        ST_TURN,
        ST_HALT,
        ST_DONE
    } hseq_state_t;
endpackage : hseq_pkg

// Three-stage pin filter: the level changes once stages two and three agree
module hseq_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin and filtered level
    input wire logic pin,
    output logic level
);
    logic [2:0] stage_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_q <= hseq_pkg::SYNC_RST;
        end else begin
            stage_q <= {stage_q[1:0], pin};
        end
    end

    // Only the later two stages are compared; the first one is metastable
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= 1'b0;
        end else if (stage_q[1] == stage_q[2]) begin
            level <= stage_q[2];
        end
    end
endmodule : hseq_sync

`default_nettype wire

// [hseq_top.sv]
// Homing sequencer for methods 2 to 9: direction, speed and stop on index
// What this block does
// RL1: Method 2 homes on the index pulse, decelerating at positive overtravel.
// RL2: Method 2, switch off: forward high, rise reverse low, index after fall.
// RL3: Method 2, switch on: reverse low, stop at index after its fall.
// RL4: Method 3 as method 2 but using the home switch.
// RL5: Method 4: reach home switch, reverse, forward low, index after rise.
// RL6: Method 5: reverse high, forward low after rise, index after fall.
// RL7: Method 6: reverse high, forward low, then reverse low, index after rise.
// RL8: Method 7, no limit: forward high, reverse low, index after fall.
// RL9: Method 7 limit hit: reverse high, low, forward, reverse, index after fall.
// RL10: Method 7, switch on: reverse low, stop at index after fall.
// RL11: Method 8, no limit: forward high, reverse low, forward, index after rise.
// RL12: Method 8 limit hit: reverse high, low, forward low, index after rise.
// RL13: Method 9, no limit: forward high then low, reverse, index after rise.
// RL14: Method 9 limit hit: reverse, forward low, reverse low, index after rise.
// RL15: Method 9, switch on: forward low, reverse, index after next rise.
// RL16: High speed is switch search speed, low speed is index search speed.
// RL17: Homing acceleration is clamped to the acceleration ceiling.
// RL18: Start level picks the branch; a limit hit is latched for its branch.
// RL19: Decelerate before each reversal; complete only once stopped on index.
`timescale 1ns/1ns
`default_nettype none

module hseq_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Homing command and settings
    input wire logic homing_start,
    input wire logic homing_abort,
    input wire logic [7:0] homing_method_select,
    input wire logic [31:0] switch_search_speed,
    input wire logic [31:0] index_search_speed,
    input wire logic [31:0] homing_acceleration,
    input wire logic [31:0] acceleration_ceiling,
    // Machine pins
    input wire logic positive_overtravel_switch,
    input wire logic home_switch,
    input wire logic encoder_index,
    // Motion feedback from the profile generator
    input wire logic motor_stopped,
    // Motion command
    output logic motion_forward,
    output logic speed_is_high,
    output logic [31:0] speed_command,
    output logic [31:0] accel_command,
    // Status
    output logic homing_busy,
    output logic homing_complete,
    output logic method_error
);
    // ****************************************************
    // Pin filters and edges
    // ****************************************************
    logic pot_lvl;
    logic home_lvl;
    logic index_lvl;
    logic pot_prev_q;
    logic home_prev_q;
    logic index_prev_q;

    hseq_sync u_sync_pot (
        .clk(clk),
        .rst(rst),
        .pin(positive_overtravel_switch),
        .level(pot_lvl)
    );

    hseq_sync u_sync_home (
        .clk(clk),
        .rst(rst),
        .pin(home_switch),
        .level(home_lvl)
    );

    hseq_sync u_sync_index (
        .clk(clk),
        .rst(rst),
        .pin(encoder_index),
        .level(index_lvl)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            pot_prev_q <= 1'b0;
            home_prev_q <= 1'b0;
            index_prev_q <= 1'b0;
        end else begin
            pot_prev_q <= pot_lvl;
            home_prev_q <= home_lvl;
            index_prev_q <= index_lvl;
        end
    end

    logic pot_rise;
    logic index_rise;
    assign pot_rise = pot_lvl & ~pot_prev_q;
    assign index_rise = index_lvl & ~index_prev_q;

    // ****************************************************
    // Segment tables
    // ****************************************************
    // Returns up to five segments, first segment in the low nibble
    function automatic logic [19:0] seg_table(
        input logic [7:0] method,
        input logic active,
        input logic limit
    );
        logic [19:0] t;
        t = '0;
        case (method)
            hseq_pkg::METHOD_POT_INDEX,
            hseq_pkg::METHOD_3: begin
                if (active) begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_NONE, hseq_pkg::SEG_RL_INDEX,
                        hseq_pkg::SEG_RL_FALL}; // [RL3] [RL4]
                end else begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_RL_INDEX, hseq_pkg::SEG_RL_FALL,
                        hseq_pkg::SEG_FH_RISE}; // [RL1] [RL2] [RL4]
                end
            end
            hseq_pkg::METHOD_4: begin
                if (active) begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_FL_INDEX, hseq_pkg::SEG_FL_RISE,
                        hseq_pkg::SEG_RL_FALL}; // [RL5]
                end else begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_FL_INDEX,
                        hseq_pkg::SEG_FL_RISE, hseq_pkg::SEG_RL_FALL,
                        hseq_pkg::SEG_FH_RISE}; // [RL5]
                end
            end
            hseq_pkg::METHOD_5: begin
                if (active) begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_NONE, hseq_pkg::SEG_FL_INDEX,
                        hseq_pkg::SEG_FL_FALL}; // [RL6]
                end else begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_FL_INDEX, hseq_pkg::SEG_FL_FALL,
                        hseq_pkg::SEG_RH_RISE}; // [RL6]
                end
            end
            hseq_pkg::METHOD_6: begin
                if (active) begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_RL_INDEX, hseq_pkg::SEG_RL_RISE,
                        hseq_pkg::SEG_FL_FALL}; // [RL7]
                end else begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_RL_INDEX,
                        hseq_pkg::SEG_RL_RISE, hseq_pkg::SEG_FL_FALL,
                        hseq_pkg::SEG_RH_RISE}; // [RL7]
                end
            end
            hseq_pkg::METHOD_7: begin
                if (active) begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_NONE, hseq_pkg::SEG_RL_INDEX,
                        hseq_pkg::SEG_RL_FALL}; // [RL10]
                end else if (limit) begin
                    t = {hseq_pkg::SEG_RL_INDEX, hseq_pkg::SEG_RL_FALL,
                        hseq_pkg::SEG_FL_RISE, hseq_pkg::SEG_RL_FALL,
                        hseq_pkg::SEG_RH_RISE}; // [RL9]
                end else begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_RL_INDEX, hseq_pkg::SEG_RL_FALL,
                        hseq_pkg::SEG_FH_RISE}; // [RL8]
                end
            end
            hseq_pkg::METHOD_8: begin
                if (active) begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_FL_INDEX, hseq_pkg::SEG_FL_RISE,
                        hseq_pkg::SEG_RL_FALL}; // [RL11]
                end else if (limit) begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_FL_INDEX,
                        hseq_pkg::SEG_FL_RISE, hseq_pkg::SEG_RL_FALL,
                        hseq_pkg::SEG_RH_RISE}; // [RL12]
                end else begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_FL_INDEX,
                        hseq_pkg::SEG_FL_RISE, hseq_pkg::SEG_RL_FALL,
                        hseq_pkg::SEG_FH_RISE}; // [RL11]
                end
            end
            hseq_pkg::METHOD_9: begin
                if (active) begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_NONE,
                        hseq_pkg::SEG_RL_INDEX, hseq_pkg::SEG_RL_RISE,
                        hseq_pkg::SEG_FL_FALL}; // [RL15]
                end else if (limit) begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_RL_INDEX,
                        hseq_pkg::SEG_RL_RISE, hseq_pkg::SEG_FL_FALL,
                        hseq_pkg::SEG_RH_RISE}; // [RL14]
                end else begin
                    t = {hseq_pkg::SEG_NONE, hseq_pkg::SEG_RL_INDEX,
                        hseq_pkg::SEG_RL_RISE, hseq_pkg::SEG_FL_FALL,
                        hseq_pkg::SEG_FH_RISE}; // [RL13]
                end
            end
            default: begin
                t = '0;
            end
        endcase
        return t;
    endfunction : seg_table

    // ****************************************************
    // Sequencer state
    // ****************************************************
    hseq_pkg::hseq_state_t state_q;
    hseq_pkg::hseq_state_t state_d;
    logic [19:0] rows_q;
    logic [7:0] method_q;
    logic active_q;
    logic limit_q;

    logic [3:0] row;
    logic row_fwd;
    logic [1:0] row_evt;
    logic dec_lvl;
    logic dec_prev;
    logic dec_rise;
    logic dec_fall;
    logic seg_end;
    logic start_ok;
    logic limit_branch;
    logic limit_hit;
    logic next_fwd;

    assign row = rows_q[hseq_pkg::ROW_W-1:0];
    assign row_fwd = row[hseq_pkg::ROW_DIR_BIT];
    assign row_evt = row[1:0];
    assign next_fwd = rows_q[hseq_pkg::ROW_W+hseq_pkg::ROW_DIR_BIT];

    // Method 2 watches the overtravel switch, all others the home switch
    assign dec_lvl = (method_q == hseq_pkg::METHOD_POT_INDEX) ?
        pot_lvl : home_lvl; // [RL1]
    assign dec_prev = (method_q == hseq_pkg::METHOD_POT_INDEX) ?
        pot_prev_q : home_prev_q;
    assign dec_rise = dec_lvl & ~dec_prev;
    assign dec_fall = ~dec_lvl & dec_prev;

    always_comb begin
        case (row_evt)
            hseq_pkg::EVT_RISE: seg_end = dec_rise;
            hseq_pkg::EVT_FALL: seg_end = dec_fall;
            hseq_pkg::EVT_INDEX: seg_end = index_rise;
            default: seg_end = 1'b0;
        endcase
    end

    assign start_ok = homing_start &&
        homing_method_select >= hseq_pkg::METHOD_FIRST &&
        homing_method_select <= hseq_pkg::METHOD_LAST;

    // Limit only counts during the first forward search of methods 7 to 9
    assign limit_branch = method_q >= hseq_pkg::METHOD_7 && !active_q &&
        !limit_q && row == hseq_pkg::SEG_FH_RISE;
    assign limit_hit = state_q == hseq_pkg::ST_SEEK && limit_branch &&
        pot_rise; // [RL18]

    always_comb begin
        state_d = state_q;
        case (state_q)
            hseq_pkg::ST_IDLE,
            hseq_pkg::ST_DONE: begin
                if (start_ok) begin
                    state_d = hseq_pkg::ST_SEEK;
                end
            end
            hseq_pkg::ST_SEEK: begin
                if (limit_hit) begin
                    state_d = hseq_pkg::ST_TURN; // [RL19]
                end else if (seg_end && row_evt == hseq_pkg::EVT_INDEX) begin
                    state_d = hseq_pkg::ST_HALT; // [RL19]
                end else if (seg_end && next_fwd != row_fwd) begin
                    state_d = hseq_pkg::ST_TURN; // [RL19]
                end
            end
            hseq_pkg::ST_TURN: begin
                if (motor_stopped) begin
                    state_d = hseq_pkg::ST_SEEK;
                end
            end
            hseq_pkg::ST_HALT: begin
                if (motor_stopped) begin
                    state_d = hseq_pkg::ST_DONE; // [RL19]
                end
            end
            default: begin
                state_d = hseq_pkg::ST_IDLE;
            end
        endcase
        if (homing_abort) begin
            state_d = hseq_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= hseq_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Branch choice: switch level taken at start, limit flag cleared there and latched on a hit
    always_ff @(posedge clk) begin
        if (rst) begin
            method_q <= 8'h00;
            active_q <= 1'b0;
            limit_q <= 1'b0;
            rows_q <= '0;
        end else if (state_d == hseq_pkg::ST_SEEK &&
                (state_q == hseq_pkg::ST_IDLE ||
                 state_q == hseq_pkg::ST_DONE)) begin
            method_q <= homing_method_select;
            active_q <= (homing_method_select == hseq_pkg::METHOD_POT_INDEX)
                ? pot_lvl : home_lvl; // [RL18]
            limit_q <= 1'b0;
            rows_q <= seg_table(homing_method_select,
                (homing_method_select == hseq_pkg::METHOD_POT_INDEX) ?
                pot_lvl : home_lvl, 1'b0);
        end else if (limit_hit && !homing_abort) begin
            limit_q <= 1'b1; // [RL18]
            rows_q <= seg_table(method_q, active_q, 1'b1);
        end else if (state_q == hseq_pkg::ST_SEEK && seg_end &&
                row_evt != hseq_pkg::EVT_INDEX) begin
            rows_q <= {hseq_pkg::SEG_NONE, rows_q[19:hseq_pkg::ROW_W]};
        end
    end

    // ****************************************************
    // Motion command outputs
    // ****************************************************
    // Speed drops to zero while turning or halting; the profile
    // generator ramps it down with the clamped acceleration.
    always_ff @(posedge clk) begin
        if (rst) begin
            motion_forward <= 1'b0;
            speed_is_high <= 1'b0;
            speed_command <= hseq_pkg::SPEED_RST;
        end else if (state_q == hseq_pkg::ST_SEEK &&
                state_d == hseq_pkg::ST_SEEK) begin
            motion_forward <= row_fwd;
            speed_is_high <= row[hseq_pkg::ROW_HIGH_BIT];
            speed_command <= row[hseq_pkg::ROW_HIGH_BIT] ?
                switch_search_speed : index_search_speed; // [RL16]
        end else begin
            speed_is_high <= 1'b0;
            speed_command <= hseq_pkg::SPEED_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            accel_command <= hseq_pkg::ACCEL_RST;
        end else if (homing_acceleration > acceleration_ceiling) begin
            accel_command <= acceleration_ceiling; // [RL17]
        end else begin
            accel_command <= homing_acceleration;
        end
    end

    // ****************************************************
    // Status
    // ****************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            homing_busy <= 1'b0;
            homing_complete <= 1'b0;
            method_error <= 1'b0;
        end else begin
            homing_busy <= state_d == hseq_pkg::ST_SEEK ||
                state_d == hseq_pkg::ST_TURN ||
                state_d == hseq_pkg::ST_HALT;
            homing_complete <= state_d == hseq_pkg::ST_DONE; // [RL19]
            if (homing_start) begin
                method_error <= !start_ok;
            end
        end
    end
endmodule : hseq_top

`default_nettype wire

// [hseq_assertions.sv]
// Port-level checker for the homing sequencer, bound to its top module
`timescale 1ns/1ns
`default_nettype none

module hseq_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command and settings
    input wire logic homing_start,
    input wire logic homing_abort,
    input wire logic [7:0] homing_method_select,
    input wire logic [31:0] switch_search_speed,
    input wire logic [31:0] index_search_speed,
    input wire logic [31:0] homing_acceleration,
    input wire logic [31:0] acceleration_ceiling,
    // Pins and feedback
    input wire logic positive_overtravel_switch,
    input wire logic home_switch,
    input wire logic motor_stopped,
    // Motion command and status
    input wire logic motion_forward,
    input wire logic speed_is_high,
    input wire logic [31:0] speed_command,
    input wire logic [31:0] accel_command,
    input wire logic homing_busy,
    input wire logic homing_complete
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic lvl;
    logic ok_m;
    // Raw level: pins are steady before a start
    assign lvl = homing_method_select == hseq_pkg::METHOD_POT_INDEX ?
        positive_overtravel_switch : home_switch;
    assign ok_m = homing_method_select >= hseq_pkg::METHOD_FIRST &&
        homing_method_select <= hseq_pkg::METHOD_LAST;

    function automatic logic first_fwd(input logic [7:0] m, input logic a);
        if (m == hseq_pkg::METHOD_5 || m == hseq_pkg::METHOD_6) begin
            return a;
        end
        return m == hseq_pkg::METHOD_9 || !a;
    endfunction : first_fwd

    property p_speed_sel;
        speed_command != 32'h0 |-> speed_command ==
            (speed_is_high ? switch_search_speed : index_search_speed);
    endproperty
    a_speed_sel: assert property (p_speed_sel)
        else $error("wrong search speed");

    property p_accel_clamp;
        !$past(rst) |-> accel_command ==
            ($past(homing_acceleration) > $past(acceleration_ceiling) ?
            $past(acceleration_ceiling) : $past(homing_acceleration));
    endproperty
    a_accel_clamp: assert property (p_accel_clamp)
        else $error("accel not clamped");

    property p_reverse_decel;
        $changed(motion_forward) |-> $past(speed_command) == 32'h0;
    endproperty
    a_reverse_decel: assert property (p_reverse_decel)
        else $error("turn while moving");

    property p_turn_waits;
        homing_busy && speed_command == 32'h0 && !motor_stopped
            |=> speed_command == 32'h0;
    endproperty
    a_turn_waits: assert property (p_turn_waits)
        else $error("resumed too early");

    property p_complete_stop;
        $rose(homing_complete) |-> $past(motor_stopped) &&
            speed_command == 32'h0 && !homing_busy;
    endproperty
    a_complete_stop: assert property (p_complete_stop)
        else $error("complete while moving");

    property p_start_busy;
        homing_start && !homing_busy && !homing_abort && ok_m
            |=> homing_busy;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start not taken");

    property p_first_seg;
        $rose(homing_busy) |=> speed_command != 32'h0 &&
            motion_forward == first_fwd($past(homing_method_select, 2),
            $past(lvl, 2)) && speed_is_high == !$past(lvl, 2);
    endproperty
    a_first_seg: assert property (p_first_seg)
        else $error("first segment wrong");

    property p_idle_still;
        !homing_busy |-> speed_command == 32'h0;
    endproperty
    a_idle_still: assert property (p_idle_still)
        else $error("speed while idle");

    property p_complete_excl;
        homing_complete |-> !homing_busy;
    endproperty
    a_complete_excl: assert property (p_complete_excl)
        else $error("complete and busy");
endmodule : hseq_assertions

bind hseq_top hseq_assertions u_hseq_chk (.*);

`default_nettype wire

// [hseq_motor.sv]
// Behavioural axis: motor, encoder index and machine switches
`timescale 1ns/1ns
`default_nettype none

module hseq_motor (
    // Clock and test control
    input wire logic clk,
    input wire logic load,
    input wire logic [7:0] load_pos,
    input wire logic slow,
    // Motion command
    input wire logic motion_forward,
    input wire logic speed_is_high,
    input wire logic [31:0] speed_command,
    // Machine pins and feedback
    output logic positive_overtravel_switch,
    output logic home_switch,
    output logic encoder_index,
    output logic motor_stopped,
    // Segment log, newest entry in the low bits
    output logic [14:0] seg_log
);
    int pos = 0;
    int idle_cnt = 0;
    int step;
    logic [2:0] seg;
    assign step = speed_is_high ? 4 : 1;
    assign seg = {1'b1, motion_forward, speed_is_high};

    always @(posedge clk) begin
        if (load) begin
            pos <= int'(load_pos);
            seg_log <= 15'h0000;
        end else if (speed_command != 32'h0) begin
            pos <= motion_forward ? pos + step : pos - step;
            if (seg != seg_log[2:0]) begin
                seg_log <= {seg_log[11:0], seg};
            end
        end
        idle_cnt <= (speed_command != 32'h0) ? 0 : idle_cnt + 1;
    end

    // A slow axis takes a dozen cycles to settle after speed drops
    assign motor_stopped = idle_cnt >= (slow ? 12 : 1);
    assign positive_overtravel_switch = pos >= 100;
    assign home_switch = pos >= 40 && pos <= 60;
    // Index 12 counts wide so even a fast pass lasts 3 cycles
    assign encoder_index = (pos % 32) < 12;
endmodule : hseq_motor

`default_nettype wire

// [hseq_top_test.sv]
// Self-checking bench for the homing sequencer
`timescale 1ns/1ns
`default_nettype none

module hseq_top_test;
    localparam logic [7:0] P0 = 8'h00;
    localparam logic [7:0] PM = 8'h32;
    localparam logic [7:0] PR = 8'h5A;
    localparam logic [7:0] PL = 8'h46;
    localparam logic [7:0] PO = 8'h6E;
    logic [7:0] tm [19] = '{8'h02, 8'h02, 8'h03, 8'h03, 8'h04, 8'h04,
        8'h05, 8'h05, 8'h06, 8'h06, 8'h07, 8'h07, 8'h07, 8'h08, 8'h08,
        8'h08, 8'h09, 8'h09, 8'h09};
    logic [7:0] tp [19] = '{P0, PO, P0, PM, P0, PM, PR, PM, PR, PM,
        P0, PL, PM, P0, PL, PM, P0, PL, PM};
    // Segments {1, forward, high}, newest in the low bits
    logic [14:0] te [19] = '{15'h3C, 15'h4, 15'h3C, 15'h4, 15'h1E6, 15'h26,
        15'h2E, 15'h6, 15'h174, 15'h34, 15'h3C, 15'h7B34, 15'h4, 15'h1E6,
        15'hF66, 15'h26, 15'h1F4, 15'hF74, 15'h34};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic homing_start = 1'b0;
    logic homing_abort = 1'b0;
    logic [7:0] method = 8'h02;
    logic [31:0] sw_spd = 32'h0000_0400;
    logic [31:0] ix_spd = 32'h0000_0040;
    logic [31:0] accel = 32'h0000_0100;
    logic [31:0] ceil = 32'h0000_0080;
    logic load = 1'b1;
    logic [7:0] load_pos = 8'h00;
    logic slow = 1'b0;
    logic pot, home, idx, stopped, fwd, hi, busy, done, merr;
    logic [31:0] spd, acc;
    logic [14:0] seg;
    int err_count = 0;
    int num_checks = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    hseq_top uut (
        .clk(clk), .rst(rst), .homing_start(homing_start),
        .homing_abort(homing_abort), .homing_method_select(method),
        .switch_search_speed(sw_spd), .index_search_speed(ix_spd),
        .homing_acceleration(accel), .acceleration_ceiling(ceil),
        .positive_overtravel_switch(pot), .home_switch(home),
        .encoder_index(idx), .motor_stopped(stopped),
        .motion_forward(fwd), .speed_is_high(hi), .speed_command(spd),
        .accel_command(acc), .homing_busy(busy),
        .homing_complete(done), .method_error(merr)
    );

    hseq_motor u_motor (
        .clk(clk), .load(load), .load_pos(load_pos), .slow(slow),
        .motion_forward(fwd), .speed_is_high(hi), .speed_command(spd),
        .positive_overtravel_switch(pot), .home_switch(home),
        .encoder_index(idx), .motor_stopped(stopped), .seg_log(seg)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // 16 cycles flush the pin filters
    task automatic launch(input logic [7:0] m, input logic [7:0] p,
                          input logic s);
        load = 1'b1;
        load_pos = p;
        slow = s;
        method = m;
        @(negedge clk);
        load = 1'b0;
        repeat (16) @(negedge clk);
        homing_start = 1'b1;
        @(negedge clk);
        homing_start = 1'b0;
    endtask : launch

    task automatic run_one(input int i);
        int n;
        launch(tm[i], tp[i], i[0]);
        n = 0;
        repeat (2) @(negedge clk);
        while (done !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check(done, 1'b1);
        if (n == 3000) begin
            report_and_stop();
        end
        check(idx, 1'b1);
    endtask : run_one

    task automatic t_methods;
        for (int i = 0; i < 10; i++) begin
            run_one(i);
            check(seg, te[i]);
        end
        for (int i = 10; i < 16; i++) begin
            run_one(i);
            check(seg, te[i]);
        end
        for (int i = 16; i < 19; i++) begin
            run_one(i);
            check(seg, te[i]);
        end
        $display("homing methods test done");
    endtask : t_methods

    task automatic t_abort;
        launch(8'h07, P0, 1'b0);
        repeat (4) @(negedge clk);
        check(spd, sw_spd);
        homing_abort = 1'b1;
        @(negedge clk);
        homing_abort = 1'b0;
        repeat (2) @(negedge clk);
        check({busy, done}, 2'h0);
        check(spd, 32'h0000_0000);
        launch(8'h0A, P0, 1'b0);
        repeat (2) @(negedge clk);
        check({merr, busy}, 2'h2);
        $display("abort test done");
    endtask : t_abort

    task automatic t_accel;
        accel = 32'h0000_0081;
        repeat (3) @(negedge clk);
        check(acc, 32'h0000_0080);
        accel = 32'h0000_007F;
        repeat (3) @(negedge clk);
        check(acc, 32'h0000_007F);
        $display("acceleration clamp test done");
    endtask : t_accel

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_accel();
        t_methods();
        t_abort();
        report_and_stop();
    end
endmodule : hseq_top_test

`default_nettype wire
